// ---- shared/nbh_pkg.sv ----
// nbh_pkg: constants and carriers for the nand bus host sequencer.
// assumes one 100 MHz core clock; all pin timing is counted in its cycles.
`default_nettype none
package nbh_pkg;
	localparam int CLK_PERIOD_NS  = 10;
	// strobe low and high widths, data access delay and busy-assert delay, in ns
	localparam int STROBE_LOW_NS  = 20;
	localparam int STROBE_HIGH_NS = 20;
	localparam int READ_ACCESS_NS = 20;
	localparam int BUSY_ASSERT_NS = 100;
	localparam int STROBE_LOW_CYC  = (STROBE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int STROBE_HIGH_CYC = (STROBE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// two extra cycles cover the input synchroniser on the io bus
	localparam int READ_LOW_CYC    = (READ_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 2;
	localparam int BUSY_WAIT_CYC   = (BUSY_ASSERT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CNT_W = 8;
	// address byte counts and field positions
	localparam logic [2:0] ADDR_FULL_CYCLES = 3'h5;
	localparam logic [2:0] ADDR_COL_CYCLES  = 3'h2;
	localparam int PLANE_ROW_BIT = 6;
	// opcodes
	localparam logic [7:0] CMD_READ_1ST   = 8'h00;
	localparam logic [7:0] CMD_READ_CONF  = 8'h30;
	localparam logic [7:0] CMD_READ_CB    = 8'h35;
	localparam logic [7:0] CMD_CACHE_RD   = 8'h31;
	localparam logic [7:0] CMD_CACHE_LAST = 8'h3f;
	localparam logic [7:0] CMD_RAND_OUT   = 8'h05;
	localparam logic [7:0] CMD_PLANE_OUT  = 8'h06;
	localparam logic [7:0] CMD_OUT_CONF   = 8'he0;
	localparam logic [7:0] CMD_PROG_1ST   = 8'h80;
	localparam logic [7:0] CMD_PROG_2ND   = 8'h81;
	localparam logic [7:0] CMD_CB_PROG    = 8'h85;
	localparam logic [7:0] CMD_PROG_CONF  = 8'h10;
	localparam logic [7:0] CMD_PROG_PLANE = 8'h11;
	localparam logic [7:0] CMD_PROG_CACHE = 8'h15;
	localparam logic [7:0] CMD_ERASE_1ST  = 8'h60;
	localparam logic [7:0] CMD_ERASE_PL   = 8'hd1;
	localparam logic [7:0] CMD_ERASE_CONF = 8'hd0;
	localparam logic [7:0] CMD_STATUS     = 8'h70;
	localparam logic [7:0] CMD_STATUS_ENH = 8'h78;
	localparam logic [7:0] CMD_RESET      = 8'hff;
	localparam logic [7:0] CMD_READ_ID    = 8'h90;
	localparam logic [7:0] CMD_PARAM_PAGE = 8'hec;
	localparam logic [7:0] CMD_UNIQUE_ID  = 8'hed;
	localparam logic [7:0] CMD_GET_FEAT   = 8'hee;
	localparam logic [7:0] CMD_SET_FEAT   = 8'hef;

	typedef enum logic [2:0] {
		OP_CMD, OP_ADDR, OP_COL, OP_WDATA, OP_RDATA, OP_WAIT
	} nbh_op_t;

	typedef struct packed {
		nbh_op_t     op;
		logic [7:0]  data;
		logic [11:0] col;
		logic [16:0] row;
	} nbh_req_t;

	typedef struct packed {
		logic       cle;
		logic       ale;
		logic       ce_n;
		logic       we_n;
		logic       re_n;
		logic       wp_n;
		logic       io_oe_n;
		logic [7:0] io_out;
	} nbh_pins_t;

	localparam nbh_pins_t PINS_RESET = '{cle: 1'b0, ale: 1'b0, ce_n: 1'b1, we_n: 1'b1,
		re_n: 1'b1, wp_n: 1'b0, io_oe_n: 1'b1, io_out: 8'h00};

	function automatic logic nbh_cmd_legal(input logic [7:0] c);
		case (c)
			CMD_READ_1ST, CMD_READ_CONF, CMD_READ_CB, CMD_CACHE_RD, CMD_CACHE_LAST,
			CMD_RAND_OUT, CMD_PLANE_OUT, CMD_OUT_CONF, CMD_PROG_1ST, CMD_PROG_2ND,
			CMD_CB_PROG, CMD_PROG_CONF, CMD_PROG_PLANE, CMD_PROG_CACHE, CMD_ERASE_1ST,
			CMD_ERASE_PL, CMD_ERASE_CONF, CMD_STATUS, CMD_STATUS_ENH, CMD_RESET,
			CMD_READ_ID, CMD_PARAM_PAGE, CMD_UNIQUE_ID, CMD_GET_FEAT,
			CMD_SET_FEAT: nbh_cmd_legal = 1'b1;
			default: nbh_cmd_legal = 1'b0;
		endcase
	endfunction

	// address byte n (0..4) of a column/row pair; unused bits are driven low
	function automatic logic [7:0] nbh_addr_byte(input logic [2:0] n, input logic [11:0] col,
		input logic [16:0] row);
		case (n)
			3'h0: nbh_addr_byte = col[7:0];
			3'h1: nbh_addr_byte = {4'h0, col[11:8]};
			3'h2: nbh_addr_byte = row[7:0];
			3'h3: nbh_addr_byte = row[15:8];
			default: nbh_addr_byte = {7'h00, row[16]};
		endcase
	endfunction
endpackage
`default_nettype wire

// ---- rtl/nbh_host.sv ----
// nbh_host: host-side sequencer that drives a multiplexed 8-bit nand bus.
// assumes the io wire is resolved outside from io_out and io_oe_n; device pins are async.
`default_nettype none
module nbh_host
	import nbh_pkg::*;
(
	// clock and reset
	input  wire logic       core_clk,
	input  wire logic       rst,
	// request port
	input  wire logic       req_valid,
	input  wire nbh_req_t   req,
	output logic            req_ready,
	// answer port
	output logic            resp_valid,
	output logic            resp_error,
	output logic [7:0]      resp_data,
	// policy
	input  wire logic       wp_allow,
	// nand pins
	output nbh_pins_t       pins,
	input  wire logic [7:0] io_in,
	input  wire logic       ready_busy_n
);
	typedef enum logic [2:0] {S_IDLE, S_SETUP, S_LOW, S_HIGH, S_WAIT} nbh_state_t;

	nbh_state_t  state_reg, state_next;
	nbh_pins_t   pins_reg, pins_next;
	nbh_req_t    req_reg, req_next;
	logic [CNT_W-1:0] cnt_reg, cnt_next;
	logic [2:0]  idx_reg, idx_next;
	logic        rv_reg, rv_next, re_reg, re_next, rdy_reg, rdy_next;
	logic [7:0]  rd_reg, rd_next;
	logic        plane_reg, plane_next, cb_plane_reg, cb_plane_next;
	logic        cb_src_reg, cb_src_next, cb_prog_reg, cb_prog_next;
	logic [7:0]  io_s1, io_s2;
	logic        rb_s1, rb_s2;

	// pins are asynchronous to core_clk
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			io_s1 <= 8'h00;
			io_s2 <= 8'h00;
			rb_s1 <= 1'b0;
			rb_s2 <= 1'b0;
		end else begin
			io_s1 <= io_in;
			io_s2 <= io_s1;
			rb_s1 <= ready_busy_n;
			rb_s2 <= rb_s1;
		end
	end

	always_comb begin
		state_next    = state_reg;
		pins_next     = pins_reg;
		req_next      = req_reg;
		cnt_next      = cnt_reg;
		idx_next      = idx_reg;
		rv_next       = 1'b0;
		re_next       = 1'b0;
		rd_next       = rd_reg;
		rdy_next      = rdy_reg;
		plane_next    = plane_reg;
		cb_plane_next = cb_plane_reg;
		cb_src_next   = cb_src_reg;
		cb_prog_next  = cb_prog_reg;
		pins_next.wp_n = wp_allow;
		case (state_reg)
			S_IDLE: begin
				pins_next.ce_n    = 1'b1;
				pins_next.io_oe_n = 1'b1;
				pins_next.cle     = 1'b0;
				pins_next.ale     = 1'b0;
				rdy_next          = 1'b1;
				if (req_valid && rdy_reg) begin
					rdy_next = 1'b0;
					req_next = req;
					idx_next = 3'h0;
					cnt_next = '0;
					if ((req.op == OP_CMD && !nbh_cmd_legal(req.data)) ||
						(req.op == OP_CMD && !rb_s2 && req.data != CMD_STATUS &&
						req.data != CMD_STATUS_ENH && req.data != CMD_RESET) ||
						(req.op == OP_ADDR && cb_prog_reg &&
						req.row[PLANE_ROW_BIT] != cb_plane_reg)) begin
						// busy allows status and reset only
						rv_next  = 1'b1;
						re_next  = 1'b1;
						rdy_next = 1'b1;
					end else begin
						pins_next.ce_n    = 1'b0;
						pins_next.cle     = (req.op == OP_CMD);
						pins_next.ale     = (req.op == OP_ADDR) || (req.op == OP_COL);
						pins_next.io_oe_n = !((req.op == OP_CMD) || (req.op == OP_ADDR) ||
							(req.op == OP_COL) || (req.op == OP_WDATA));
						// first address byte is column low
						pins_next.io_out  = (req.op == OP_ADDR || req.op == OP_COL) ?
							nbh_addr_byte(3'h0, req.col, req.row) : req.data;
						state_next = (req.op == OP_WAIT) ? S_WAIT : S_SETUP;
					end
				end
			end
			S_SETUP: begin
				cnt_next = '0;
				state_next = S_LOW;
				// read cycle keeps latches low, write strobe high
				if (req_reg.op == OP_RDATA)
					pins_next.re_n = 1'b0;
				else
					pins_next.we_n = 1'b0;
			end
			S_LOW: begin
				cnt_next = cnt_reg + 1'b1;
				if (req_reg.op == OP_RDATA && cnt_reg == CNT_W'(READ_LOW_CYC - 1)) begin
					rd_next        = io_s2;
					pins_next.re_n = 1'b1;
					cnt_next       = '0;
					state_next     = S_HIGH;
				end else if (req_reg.op != OP_RDATA &&
					cnt_reg == CNT_W'(STROBE_LOW_CYC - 1)) begin
					pins_next.we_n = 1'b1;
					cnt_next       = '0;
					state_next     = S_HIGH;
				end
			end
			S_HIGH: begin
				cnt_next = cnt_reg + 1'b1;
				if (cnt_reg == CNT_W'(STROBE_HIGH_CYC - 1)) begin
					cnt_next = '0;
					// next address byte, unused bits low
					if ((req_reg.op == OP_ADDR && idx_reg != ADDR_FULL_CYCLES - 3'h1) ||
						(req_reg.op == OP_COL && idx_reg != ADDR_COL_CYCLES - 3'h1)) begin
						idx_next = idx_reg + 3'h1;
						pins_next.io_out = nbh_addr_byte(idx_reg + 3'h1, req_reg.col,
							req_reg.row);
						state_next = S_SETUP;
					end else begin
						if (req_reg.op == OP_ADDR)
							plane_next = req_reg.row[PLANE_ROW_BIT];
						if (req_reg.op == OP_CMD) begin
							if (req_reg.data == CMD_READ_CB) begin
								cb_src_next   = 1'b1;
								cb_plane_next = plane_reg;
							end
							if (req_reg.data == CMD_CB_PROG && cb_src_reg)
								cb_prog_next = 1'b1;
							if (req_reg.data == CMD_PROG_CONF || req_reg.data == CMD_RESET) begin
								cb_prog_next = 1'b0;
								cb_src_next  = 1'b0;
							end
						end
						pins_next.cle = 1'b0;
						pins_next.ale = 1'b0;
						rv_next       = 1'b1;
						rdy_next      = 1'b1;
						state_next    = S_IDLE;
					end
				end
			end
			S_WAIT: begin
				if (cnt_reg != CNT_W'(BUSY_WAIT_CYC))
					cnt_next = cnt_reg + 1'b1;
				else if (rb_s2) begin
					rv_next    = 1'b1;
					rdy_next   = 1'b1;
					state_next = S_IDLE;
				end
			end
			default: state_next = S_IDLE;
		endcase
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			state_reg    <= S_IDLE;
			pins_reg     <= PINS_RESET;
			req_reg      <= '0;
			cnt_reg      <= '0;
			idx_reg      <= 3'h0;
			rv_reg       <= 1'b0;
			re_reg       <= 1'b0;
			rd_reg       <= 8'h00;
			rdy_reg      <= 1'b0;
			plane_reg    <= 1'b0;
			cb_plane_reg <= 1'b0;
			cb_src_reg   <= 1'b0;
			cb_prog_reg  <= 1'b0;
		end else begin
			state_reg    <= state_next;
			pins_reg     <= pins_next;
			req_reg      <= req_next;
			cnt_reg      <= cnt_next;
			idx_reg      <= idx_next;
			rv_reg       <= rv_next;
			re_reg       <= re_next;
			rd_reg       <= rd_next;
			rdy_reg      <= rdy_next;
			plane_reg    <= plane_next;
			cb_plane_reg <= cb_plane_next;
			cb_src_reg   <= cb_src_next;
			cb_prog_reg  <= cb_prog_next;
		end
	end

	assign pins       = pins_reg;
	assign req_ready  = rdy_reg;
	assign resp_valid = rv_reg;
	assign resp_error = re_reg;
	assign resp_data  = rd_reg;

	property p_col_low;
		@(posedge core_clk) disable iff (rst)
		(pins_reg.ale && !pins_reg.we_n && idx_reg == 3'h0) |->
			pins_reg.io_out == req_reg.col[7:0];
	endproperty
	a_col_low: assert property (p_col_low) else $error("column low byte wrong");

	property p_row_top;
		@(posedge core_clk) disable iff (rst)
		(pins_reg.ale && !pins_reg.we_n && idx_reg == 3'h4) |->
			pins_reg.io_out == {7'h00, req_reg.row[16]};
	endproperty
	a_row_top: assert property (p_row_top) else $error("fifth address byte wrong");

	property p_col_pad;
		@(posedge core_clk) disable iff (rst)
		(pins_reg.ale && !pins_reg.we_n && idx_reg == 3'h1) |->
			pins_reg.io_out[7:4] == 4'h0;
	endproperty
	a_col_pad: assert property (p_col_pad) else $error("unused address bits high");

	property p_rd_pins;
		@(posedge core_clk) disable iff (rst)
		!pins_reg.re_n |-> (!pins_reg.cle && !pins_reg.ale && !pins_reg.ce_n &&
			pins_reg.we_n && pins_reg.io_oe_n);
	endproperty
	a_rd_pins: assert property (p_rd_pins) else $error("bad pins in read cycle");

	property p_legal;
		@(posedge core_clk) disable iff (rst)
		(pins_reg.cle && !pins_reg.we_n) |-> nbh_cmd_legal(pins_reg.io_out);
	endproperty
	a_legal: assert property (p_legal) else $error("undefined opcode issued");

	property p_col_only;
		@(posedge core_clk) disable iff (rst)
		(req_reg.op == OP_COL && state_reg != S_IDLE) |-> idx_reg < ADDR_COL_CYCLES;
	endproperty
	a_col_only: assert property (p_col_only) else $error("column op left page");

	property p_cb_plane;
		@(posedge core_clk) disable iff (rst)
		(cb_prog_reg && pins_reg.ale && !pins_reg.we_n && idx_reg == 3'h2) |->
			pins_reg.io_out[PLANE_ROW_BIT] == cb_plane_reg;
	endproperty
	a_cb_plane: assert property (p_cb_plane) else $error("copy-back plane crossed");

	property p_wait_busy;
		@(posedge core_clk) disable iff (rst)
		(state_reg == S_WAIT && !rb_s2) |=> !rv_reg;
	endproperty
	a_wait_busy: assert property (p_wait_busy) else $error("answer while busy");
endmodule
`default_nettype wire

// ---- verif/nbh_dev_model.sv ----
// nbh_dev_model: behavioural nand device facing the host sequencer pins.
// assumes pins come straight from the host; resolves the io and ready/busy wires.
`default_nettype none
module nbh_dev_model
	import nbh_pkg::*;
#(
	parameter int BUSY_NS   = 400,
	parameter int ACCESS_NS = 15
)(
	// host pins
	input  wire nbh_pins_t pins,
	// resolved wires
	output logic [7:0]     io_wire,
	output logic           rb_wire,
	// observation
	output logic [7:0]     cmd_reg,
	output logic [39:0]    addr_reg
);
	timeunit 1ns;
	timeprecision 100ps;

	logic       busy;
	logic       drive;
	logic [7:0] out_byte;
	logic [7:0] last_byte;
	logic [11:0] col_ptr;
	int         n_addr;

	initial begin
		busy = 1'b0;
		drive = 1'b0;
		out_byte = 8'h00;
		last_byte = 8'h00;
		col_ptr = 12'h000;
		n_addr = 0;
		addr_reg = 40'h0;
		cmd_reg = 8'h00;
	end

	assign rb_wire = busy ? 1'b0 : 1'b1;
	// released io shows the inverse of the last level, never a stale copy
	assign io_wire = !pins.io_oe_n ? pins.io_out : (drive ? out_byte : ~last_byte);

	always @(posedge pins.we_n) begin
		if (!pins.ce_n) begin
			last_byte = pins.io_out;
			if (pins.cle && (!busy || pins.io_out inside {8'h70, 8'h78, 8'hff})) begin
				cmd_reg = pins.io_out;
				// output confirm after two column cycles moves the column
				if (pins.io_out == 8'he0 && n_addr == 2)
					col_ptr = {addr_reg[35:32], addr_reg[31:24]};
				n_addr = 0;
				if (pins.io_out inside {8'h30, 8'h35})
					col_ptr = addr_reg[11:0];
				// busy opcodes, protect blocks program and erase
				if (pins.io_out inside {8'h30, 8'h35, 8'h31, 8'h3f, 8'hff} ||
					(pins.io_out inside {8'h10, 8'h15, 8'hd0} && pins.wp_n))
					busy = 1'b1;
			end else if (pins.ale && !busy && n_addr < 5) begin
				addr_reg = {pins.io_out, addr_reg[39:8]};
				n_addr++;
			end else if (!pins.cle && !pins.ale && !busy) begin
				col_ptr++;
			end
		end
	end

	always @(posedge busy) begin
		#(BUSY_NS);
		busy = 1'b0;
	end

	// byte valid an access delay after strobe fall
	always @(negedge pins.re_n) begin
		if (!pins.ce_n) begin
			#(ACCESS_NS);
			out_byte = col_ptr[7:0] ^ 8'h5a;
			drive = 1'b1;
		end
	end

	// column advances per pulse, then release
	always @(posedge pins.re_n) begin
		if (drive) begin
			last_byte = out_byte;
			col_ptr++;
		end
		drive = 1'b0;
	end
endmodule
`default_nettype wire

// ---- verif/nand_bus_command_interface_test.sv ----
// nand_bus_command_interface_test: self-checking bench for the nand host sequencer.
// assumes the device model resolves io and ready/busy; one 100 MHz clock.
`default_nettype none
module nand_bus_command_interface_test;
	import nbh_pkg::*;
	timeunit 1ns;
	timeprecision 100ps;

	logic        core_clk;
	logic        rst;
	logic        req_valid;
	logic        wp_allow;
	nbh_req_t    req;
	logic        req_ready;
	logic        resp_valid;
	logic        resp_error;
	logic [7:0]  resp_data;
	nbh_pins_t   pins;
	logic [7:0]  io_wire;
	logic        rb_wire;
	logic [7:0]  cmd_reg;
	logic [39:0] addr_reg;
	int          n_fail;
	int          n_compared;

	nbh_host DUT (.core_clk(core_clk), .rst(rst), .req_valid(req_valid), .req(req),
		.req_ready(req_ready), .resp_valid(resp_valid), .resp_error(resp_error),
		.resp_data(resp_data), .wp_allow(wp_allow), .pins(pins), .io_in(io_wire),
		.ready_busy_n(rb_wire));

	nbh_dev_model dev (.pins(pins), .io_wire(io_wire), .rb_wire(rb_wire),
		.cmd_reg(cmd_reg), .addr_reg(addr_reg));

	always #5 core_clk = ~core_clk;

	task automatic tally_and_finish();
		$display("compared %0d, failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input logic [39:0] got, input logic [39:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// one request, held until taken; bounded wait for the answer pulse
	task automatic xfer(input nbh_op_t op, input logic [7:0] d, input logic [11:0] c = 12'h0,
		input logic [16:0] r = 17'h0, input logic err = 1'b0);
		int i;
		@(posedge core_clk);
		req_valid <= 1'b1;
		req <= '{op: op, data: d, col: c, row: r};
		i = 0;
		do begin
			@(posedge core_clk);
			i++;
		end while (req_ready !== 1'b1 && i < 300);
		req_valid <= 1'b0;
		while (resp_valid !== 1'b1 && i < 300) begin
			@(posedge core_clk);
			i++;
		end
		if (i >= 300) begin
			n_fail++;
			tally_and_finish();
		end else begin
			chk(40'(resp_error), 40'(err));
		end
	endtask

	task automatic t_page_read();
		xfer(OP_ADDR, 8'h00, 12'habc, 17'h12345);
		xfer(OP_CMD, CMD_READ_CONF);
		chk(addr_reg, 40'h01_23_45_0a_bc);
		chk(40'(rb_wire), 40'h0);
		xfer(OP_WAIT, 8'h00);
		chk(40'(rb_wire), 40'h1);
		xfer(OP_RDATA, 8'h00);
		chk(40'(resp_data), 40'he6);
		xfer(OP_RDATA, 8'h00);
		chk(40'(resp_data), 40'he7);
		xfer(OP_CMD, CMD_RAND_OUT);
		xfer(OP_COL, 8'h00, 12'h100);
		chk(40'(addr_reg[39:24]), 40'h01_00);
		xfer(OP_CMD, CMD_OUT_CONF);
		xfer(OP_RDATA, 8'h00);
		chk(40'(resp_data), 40'h5a);
		$display("page read test done");
	endtask

	task automatic t_opcodes();
		logic [7:0] ops [16] = '{8'h00, 8'h05, 8'h06, 8'he0, 8'h80, 8'h81, 8'h85, 8'h11,
			8'h60, 8'hd1, 8'h90, 8'hec, 8'hed, 8'hee, 8'hef, 8'h78};
		foreach (ops[k]) begin
			xfer(OP_CMD, ops[k]);
			chk(40'(cmd_reg), 40'(ops[k]));
		end
		// undefined opcode must never reach the pins
		xfer(OP_CMD, 8'h01, 12'h0, 17'h0, 1'b1);
		chk(40'(cmd_reg), 40'h78);
		$display("opcode test done");
	endtask

	task automatic t_protect();
		@(posedge core_clk);
		wp_allow <= 1'b0;
		xfer(OP_CMD, CMD_ERASE_1ST);
		xfer(OP_ADDR, 8'h00, 12'h0, 17'h00840);
		xfer(OP_CMD, CMD_ERASE_CONF);
		chk(40'(pins.wp_n), 40'h0);
		chk(40'(rb_wire), 40'h1);
		wp_allow <= 1'b1;
		xfer(OP_CMD, CMD_ERASE_1ST);
		xfer(OP_ADDR, 8'h00, 12'h0, 17'h00840);
		xfer(OP_CMD, CMD_ERASE_CONF);
		chk(40'(rb_wire), 40'h0);
		// two cycles of ready/busy synchroniser plus margin
		repeat (4) @(posedge core_clk);
		xfer(OP_CMD, CMD_PROG_1ST, 12'h0, 17'h0, 1'b1);
		xfer(OP_CMD, CMD_STATUS);
		chk(40'(cmd_reg), 40'h70);
		xfer(OP_WAIT, 8'h00);
		$display("protect test done");
	endtask

	task automatic t_copyback();
		xfer(OP_CMD, CMD_READ_1ST);
		xfer(OP_ADDR, 8'h00, 12'h010, 17'h00000);
		xfer(OP_CMD, CMD_READ_CB);
		xfer(OP_WAIT, 8'h00);
		xfer(OP_CMD, CMD_CB_PROG);
		xfer(OP_ADDR, 8'h00, 12'h010, 17'h00040, 1'b1);
		// same plane as the source, so this one reaches the pins
		xfer(OP_ADDR, 8'h00, 12'h010, 17'h10023);
		chk(addr_reg, 40'h01_00_23_00_10);
		xfer(OP_WDATA, 8'ha5);
		// released io shows the inverse of the byte the device latched last
		@(posedge core_clk);
		chk(40'(io_wire), 40'h5a);
		xfer(OP_CMD, CMD_PROG_CONF);
		chk(40'(rb_wire), 40'h0);
		xfer(OP_CMD, CMD_RESET);
		chk(40'(cmd_reg), 40'hff);
		xfer(OP_WAIT, 8'h00);
		$display("copy-back test done");
	endtask

	initial begin
		core_clk = 1'b0;
		rst = 1'b1;
		req_valid = 1'b0;
		req = '0;
		wp_allow = 1'b1;
		n_fail = 0;
		n_compared = 0;
		repeat (4) @(posedge core_clk);
		rst <= 1'b0;
		repeat (5) @(posedge core_clk);
		t_page_read();
		t_opcodes();
		t_protect();
		t_copyback();
		tally_and_finish();
	end
endmodule
`default_nettype wire
